// *** mfid_pkg.sv ***
// constants shared by the multi-function input decoder
package mfid_pkg;

    localparam int NUM_TERM = 6;
    localparam int CODE_W   = 7;
    localparam int NUM_FN   = 74;
    localparam logic [CODE_W-1:0] CODE_MAX = 7'h49;

    // function codes
    localparam logic [CODE_W-1:0] FN_FWD      = 7'h00;
    localparam logic [CODE_W-1:0] FN_REV      = 7'h01;
    localparam logic [CODE_W-1:0] FN_3WIRE    = 7'h02;
    localparam int FN_LOCREM   = 3;
    localparam int FN_CMDSRC   = 4;
    localparam int FN_STEP0    = 5;
    localparam int STEP_BITS   = 4;
    localparam int FN_JOG      = 9;
    localparam int FN_UP       = 10;
    localparam int FN_DOWN     = 11;
    localparam int FN_UP2      = 12;
    localparam int FN_DOWN2    = 13;
    localparam int FN_FORWARD_INCH_REQUEST     = 14;
    localparam int FN_REVERSE_INCH_REQUEST     = 15;
    localparam int FN_RAMPSEL  = 16;
    localparam int FN_RAMPHOLD = 18;
    localparam int FN_BBLOCK   = 19;
    localparam int FN_FSTOP    = 21;
    localparam int FN_EXTF0    = 23;
    localparam int EXTF_NUM    = 16;
    localparam int FN_FRESET   = 39;
    localparam int FN_OVERHEAT = 40;
    localparam int FN_COMM     = 45;
    localparam int FN_PID0     = 46;
    localparam int PID_NUM     = 4;
    localparam int FN_PIDCHAR  = 50;
    localparam int FN_MOTOR2   = 51;
    localparam int FN_TIMER    = 52;
    localparam int FN_OFFS0    = 53;
    localparam int OFFS_NUM    = 3;
    localparam int FN_LOCKOUT  = 60;
    localparam int FN_AHOLD    = 61;
    localparam int FN_DCBRAKE  = 65;
    localparam int FN_ENABLE   = 69;

    // selector values after reset, listed terminal 6 down to terminal 1
    localparam logic [NUM_TERM-1:0][CODE_W-1:0] SEL_DEFAULT =
        {7'h13, 7'h09, 7'h27, 7'h17, 7'h01, 7'h00};

    // timing
    localparam longint CLK_HZ          = 25_000_000;
    localparam longint RUN_CLOSE_MIN_MS = 2;
    localparam int RUN_CLOSE_CYCLES_DEF =
        int'((RUN_CLOSE_MIN_MS * CLK_HZ + 999) / 1000);
    localparam int FLASH_DIV_W_DEF = 22;
    localparam int SYNC_STAGES     = 2;

    // power-up sequencing, gray along settle -> sync -> check -> normal
    typedef enum logic [1:0] {
        MFID_SETTLE = 2'b00,
        MFID_SYNC   = 2'b01,
        MFID_CHECK  = 2'b11,
        MFID_NORMAL = 2'b10
    } mfid_phase_type;

endpackage

// *** mfid_sync.sv ***
// two-stage synchroniser for the terminal inputs
module mfid_sync #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // raw and synchronised levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import mfid_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } mfid_sync_state_type;

    mfid_sync_state_type state_q;
    mfid_sync_state_type state_d;

    always_comb begin
        state_d        = state_q;
        state_d.meta   = async_in;
        // first stage is read only by the second stage
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stable;

endmodule // mfid_sync

// *** mfid_decoder.sv ***
// multi-function digital input decoder: six terminals to internal commands
module mfid_decoder
    import mfid_pkg::*;
#(
    parameter int RUN_CLOSE_CYCLES = mfid_pkg::RUN_CLOSE_CYCLES_DEF,
    parameter int FLASH_DIV_W      = mfid_pkg::FLASH_DIV_W_DEF
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // contact inputs, high when closed
    input  wire logic                          input_terminal_1,
    input  wire logic                          input_terminal_2,
    input  wire logic                          input_terminal_3,
    input  wire logic                          input_terminal_4,
    input  wire logic                          input_terminal_5,
    input  wire logic                          input_terminal_6,
    // selector configuration, taken on select_load
    input  wire logic                          select_load,
    input  wire logic [mfid_pkg::CODE_W-1:0]   terminal_1_function_select,
    input  wire logic [mfid_pkg::CODE_W-1:0]   terminal_2_function_select,
    input  wire logic [mfid_pkg::CODE_W-1:0]   terminal_3_function_select,
    input  wire logic [mfid_pkg::CODE_W-1:0]   terminal_4_function_select,
    input  wire logic [mfid_pkg::CODE_W-1:0]   terminal_5_function_select,
    input  wire logic [mfid_pkg::CODE_W-1:0]   terminal_6_function_select,
    output logic                               select_rejected,
    // drive context
    input  wire logic                          powerup_run_accept,
    input  wire logic                          keypad_source_toggle_key,
    input  wire logic                          motor_running,
    // run sequencing
    output logic                               run_forward,
    output logic                               run_reverse,
    output logic                               powerup_run_blocked,
    output logic                               status_indicator_flash,
    // command source
    output logic                               local_mode_indicator,
    output logic                               source_select_b,
    // speed commands
    output logic [mfid_pkg::STEP_BITS-1:0]     preset_index,
    output logic                               jog_select,
    output logic                               freq_up,
    output logic                               freq_down,
    output logic                               bias_up,
    output logic                               bias_down,
    output logic                               forward_inch_request,
    output logic                               reverse_inch_request,
    output logic                               ramp_time_select,
    output logic                               ramp_hold,
    // stop and fault requests
    output logic                               output_shutoff,
    output logic                               fast_stop,
    output logic [mfid_pkg::EXTF_NUM-1:0]      external_fault,
    output logic                               fault_reset,
    output logic                               external_overheat_alarm,
    // miscellaneous requests
    output logic                               comm_mode,
    output logic [mfid_pkg::PID_NUM-1:0]       pid_control,
    output logic                               pid_input_switch,
    output logic                               motor_2_select,
    output logic                               timer_input,
    output logic [mfid_pkg::OFFS_NUM-1:0]      offset_freq,
    output logic                               param_lockout,
    output logic                               analog_ref_hold,
    output logic                               dc_brake_request,
    output logic                               drive_enable
);
    import mfid_pkg::*;

    localparam int RUN_CNT_W = $clog2(RUN_CLOSE_CYCLES + 2);
    localparam logic [RUN_CNT_W-1:0] RUN_CNT_LIMIT = RUN_CNT_W'(RUN_CLOSE_CYCLES);

    typedef struct packed {
        logic [NUM_TERM-1:0][CODE_W-1:0] sel;
        mfid_phase_type                  phase;
        logic                            w3_run;
        logic [RUN_CNT_W-1:0]            run_cnt;
        logic                            pu_block;
        logic [FLASH_DIV_W-1:0]          flash_cnt;
        logic                            local_sel;
        logic                            src_b;
        logic                            reject;
        logic                            run_fwd;
        logic                            run_rev;
        logic                            flash;
        logic [STEP_BITS-1:0]            step;
        logic [NUM_FN-1:0]               fn_out;
        logic                            up;
        logic                            down;
        logic                            up2;
        logic                            down2;
        logic                            enable;
    } mfid_state_type;

    mfid_state_type state_q;
    mfid_state_type state_d;

    logic [NUM_TERM-1:0]             term_raw;
    logic [NUM_TERM-1:0]             term_lvl;
    logic [NUM_TERM-1:0][CODE_W-1:0] sel_in;
    logic [NUM_TERM-1:0]             term_valid;
    logic [NUM_TERM-1:0]             is_3wire;
    logic [NUM_FN-1:0]               term_hot [NUM_TERM];
    logic                            three_wire;

    assign term_raw = {input_terminal_6, input_terminal_5, input_terminal_4,
                       input_terminal_3, input_terminal_2, input_terminal_1};
    assign sel_in   = {terminal_6_function_select, terminal_5_function_select,
                       terminal_4_function_select, terminal_3_function_select,
                       terminal_2_function_select, terminal_1_function_select};

    mfid_sync #(
        .WIDTH (NUM_TERM)
    ) u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (term_raw),
        .sync_out (term_lvl)
    );

    // per-terminal decode into a one-hot function vector
    for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
        assign is_3wire[t]   = (t >= 2) && (state_q.sel[t] == FN_3WIRE);
        // terminals 1 and 2 are taken over by run and stop in three-wire mode
        assign term_valid[t] = (state_q.sel[t] <= CODE_MAX)
                             && !((t < 2) && (state_q.sel[t] == FN_3WIRE))
                             && !((t < 2) && three_wire);
        assign term_hot[t]   = term_valid[t]
                             ? (NUM_FN'(1) << state_q.sel[t]) : '0;
    end

    assign three_wire = |is_3wire;

    logic [NUM_FN-1:0] fn_asg;
    logic [NUM_FN-1:0] fn_act;
    logic              run_present;
    logic              run_ok;
    logic              w3_dir_rev;
    logic              want_local;
    logic              want_src_b;

    always_comb begin
        fn_asg = '0;
        fn_act = '0;
        for (int t = 0; t < NUM_TERM; t++) begin
            fn_asg = fn_asg | term_hot[t];
            fn_act = fn_act | (term_lvl[t] ? term_hot[t] : '0);
        end
        // retained codes set bits that nothing below reads
        w3_dir_rev  = fn_act[FN_3WIRE];
        run_present = three_wire ? term_lvl[0]
                                 : (fn_act[FN_FWD] | fn_act[FN_REV]);
        run_ok      = !state_q.pu_block && (state_q.phase == MFID_NORMAL);
        // terminal owns local/remote when assigned, else the keypad key toggles
        if (fn_asg[FN_LOCREM]) begin
            want_local = fn_act[FN_LOCREM];
        end else begin
            want_local = state_q.local_sel ^ keypad_source_toggle_key;
        end
        want_src_b = fn_asg[FN_CMDSRC] && fn_act[FN_CMDSRC];
    end

    always_comb begin
        state_d        = state_q;
        state_d.reject = 1'b0;

        if (select_load) begin
            for (int t = 0; t < NUM_TERM; t++) begin
                if (sel_in[t] > CODE_MAX || (t < 2 && sel_in[t] == FN_3WIRE)) begin
                    state_d.reject = 1'b1;
                end else begin
                    state_d.sel[t] = sel_in[t];
                end
            end
        end

        // power-up: two cycles let both synchroniser stages fill before the one-time run check
        case (state_q.phase)
            MFID_SETTLE: state_d.phase = MFID_SYNC;
            MFID_SYNC:   state_d.phase = MFID_CHECK;
            MFID_CHECK: begin
                state_d.phase = MFID_NORMAL;
                if (run_present && !powerup_run_accept) begin
                    state_d.pu_block = 1'b1;
                end
            end
            MFID_NORMAL: state_d.phase = MFID_NORMAL;
            default:     state_d.phase = MFID_SETTLE;
        endcase
        // the block lifts only once the run command has been taken away
        if (state_q.pu_block && !run_present) begin
            state_d.pu_block = 1'b0;
        end
        state_d.flash_cnt = state_q.pu_block ? state_q.flash_cnt + 1'b1 : '0;
        state_d.flash     = state_q.pu_block && state_q.flash_cnt[FLASH_DIV_W-1];

        // three-wire run latch; a short contact bounce must not start the motor
        if (!three_wire || !term_lvl[1]) begin
            state_d.w3_run  = 1'b0;
            state_d.run_cnt = '0;
        end else if (term_lvl[0]) begin
            if (state_q.run_cnt == RUN_CNT_LIMIT) begin
                state_d.w3_run = 1'b1;
            end else begin
                state_d.run_cnt = state_q.run_cnt + 1'b1;
            end
        end else begin
            state_d.run_cnt = '0;
        end

        if (state_q.local_sel || !run_ok) begin
            state_d.run_fwd = 1'b0;
            state_d.run_rev = 1'b0;
        end else if (three_wire) begin
            state_d.run_fwd = state_d.w3_run && !w3_dir_rev;
            state_d.run_rev = state_d.w3_run && w3_dir_rev;
        end else begin
            state_d.run_fwd = fn_act[FN_FWD] && !fn_act[FN_REV];
            state_d.run_rev = fn_act[FN_REV] && !fn_act[FN_FWD];
        end

        // source changes wait until the motor has stopped
        if (!motor_running) begin
            state_d.local_sel = want_local;
            state_d.src_b     = want_src_b;
        end

        state_d.fn_out = fn_act;
        state_d.step   = fn_act[FN_STEP0 +: STEP_BITS];
        state_d.up     = fn_asg[FN_UP] && fn_asg[FN_DOWN]
                       && fn_act[FN_UP] && !fn_act[FN_DOWN];
        state_d.down   = fn_asg[FN_UP] && fn_asg[FN_DOWN]
                       && fn_act[FN_DOWN] && !fn_act[FN_UP];
        state_d.up2    = fn_act[FN_UP2] && !fn_act[FN_DOWN2];
        state_d.down2  = fn_act[FN_DOWN2] && !fn_act[FN_UP2];
        // an unassigned enable input leaves the drive enabled
        state_d.enable = !fn_asg[FN_ENABLE] || fn_act[FN_ENABLE];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q        <= '0;
            state_q.sel    <= SEL_DEFAULT;
            state_q.phase  <= MFID_SETTLE;
            state_q.enable <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign select_rejected         = state_q.reject;
    assign run_forward             = state_q.run_fwd;
    assign run_reverse             = state_q.run_rev;
    assign powerup_run_blocked     = state_q.pu_block;
    assign status_indicator_flash  = state_q.flash;
    assign local_mode_indicator    = state_q.local_sel;
    assign source_select_b         = state_q.src_b;
    assign preset_index            = state_q.step;
    assign jog_select              = state_q.fn_out[FN_JOG];
    assign freq_up                 = state_q.up;
    assign freq_down               = state_q.down;
    assign bias_up                 = state_q.up2;
    assign bias_down               = state_q.down2;
    assign forward_inch_request    = state_q.fn_out[FN_FORWARD_INCH_REQUEST];
    assign reverse_inch_request    = state_q.fn_out[FN_REVERSE_INCH_REQUEST];
    assign ramp_time_select        = state_q.fn_out[FN_RAMPSEL];
    assign ramp_hold               = state_q.fn_out[FN_RAMPHOLD];
    assign output_shutoff          = state_q.fn_out[FN_BBLOCK];
    assign fast_stop               = state_q.fn_out[FN_FSTOP];
    assign external_fault          = state_q.fn_out[FN_EXTF0 +: EXTF_NUM];
    assign fault_reset             = state_q.fn_out[FN_FRESET];
    assign external_overheat_alarm = state_q.fn_out[FN_OVERHEAT];
    assign comm_mode               = state_q.fn_out[FN_COMM];
    assign pid_control             = state_q.fn_out[FN_PID0 +: PID_NUM];
    assign pid_input_switch        = state_q.fn_out[FN_PIDCHAR];
    assign motor_2_select          = state_q.fn_out[FN_MOTOR2];
    assign timer_input             = state_q.fn_out[FN_TIMER];
    assign offset_freq             = state_q.fn_out[FN_OFFS0 +: OFFS_NUM];
    assign param_lockout           = state_q.fn_out[FN_LOCKOUT];
    assign analog_ref_hold         = state_q.fn_out[FN_AHOLD];
    assign dc_brake_request        = state_q.fn_out[FN_DCBRAKE];
    assign drive_enable            = state_q.enable;

    // checks
    a_reset_defaults: assert property (@(posedge clk)
        reset |=> state_q.sel == SEL_DEFAULT)
        else $error("selectors not at defaults after reset");

    a_select_range: assert property (@(posedge clk) disable iff (reset)
        select_load && sel_in[0] > CODE_MAX |=> $stable(state_q.sel[0]) && select_rejected)
        else $error("out-of-range code accepted");

    a_run_not_early: assert property (@(posedge clk) disable iff (reset)
        $rose(state_q.w3_run) |-> state_q.run_cnt == RUN_CNT_LIMIT && $past(term_lvl[0]))
        else $error("three-wire run started before minimum closure");

    a_stop_opens: assert property (@(posedge clk) disable iff (reset)
        three_wire && !term_lvl[1] |=> !state_q.w3_run ##1 !run_forward && !run_reverse)
        else $error("stop input opening did not stop the motor");

    a_dir_reverse: assert property (@(posedge clk) disable iff (reset)
        three_wire && state_d.w3_run && run_ok && !state_q.local_sel && w3_dir_rev
        |=> run_reverse && !run_forward)
        else $error("closed direction input did not select reverse");

    a_powerup_block: assert property (@(posedge clk) disable iff (reset)
        state_q.phase == MFID_CHECK && run_present && !powerup_run_accept
        |=> powerup_run_blocked ##1 !run_forward && !run_reverse)
        else $error("run present at power-up not blocked");

    a_led_local: assert property (@(posedge clk) disable iff (reset)
        fn_asg[FN_LOCREM] && !motor_running
        |=> local_mode_indicator == $past(fn_act[FN_LOCREM]))
        else $error("local indicator does not follow the terminal");

    a_local_no_run: assert property (@(posedge clk) disable iff (reset)
        state_q.local_sel |=> !run_forward && !run_reverse)
        else $error("terminal run command passed in local mode");

    a_local_frozen: assert property (@(posedge clk) disable iff (reset)
        motor_running |=> $stable(state_q.local_sel))
        else $error("local/remote changed during run");

    a_source_frozen: assert property (@(posedge clk) disable iff (reset)
        motor_running |=> $stable(source_select_b))
        else $error("command source changed during run");

    a_preset_index: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> preset_index == $past(fn_act[FN_STEP0 +: STEP_BITS]))
        else $error("preset index does not follow step inputs");

    a_updown_pair: assert property (@(posedge clk) disable iff (reset)
        fn_act[FN_UP] && fn_act[FN_DOWN] |=> !freq_up && !freq_down)
        else $error("up and down both closed did not hold");

    c_three_wire_run: cover property (@(posedge clk) disable iff (reset)
        $rose(run_forward) && three_wire);
    c_powerup_block: cover property (@(posedge clk) disable iff (reset)
        $fell(powerup_run_blocked));
    c_local_switch: cover property (@(posedge clk) disable iff (reset)
        $rose(local_mode_indicator));

endmodule // mfid_decoder

// *** mfid_contacts.sv ***
// contact closures feeding the six terminal inputs
module mfid_contacts (
    // clock
    input  wire logic       clk,
    // wanted closures, one bit a terminal
    input  wire logic [5:0] close_req,
    // contact levels, high when closed
    output logic      [5:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    // a contact moves just after an edge, like a relay wired to the bench
    always_ff @(posedge clk) begin
        level <= close_req;
    end
endmodule // mfid_contacts

// *** mfid_decoder_test.sv ***
// self-checking bench for the multi-function input decoder
module mfid_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mfid_pkg::*;
    localparam logic [54:0] DE = 55'h1 << 47, RF = 55'h1 << 48, RR = 55'h1 << 49,
        BLK = 55'h1 << 50, LOC = 55'h1 << 51, SB = 55'h1 << 52, REJ = 55'h1 << 53,
        FLS = 55'h1 << 54;
    logic clk = 0, reset = 1, select_load = 0, chk = 0, motor_running = 0;
    logic powerup_run_accept = 1, keypad_source_toggle_key = 0, rej = 0, fl = 0;
    logic [5:0] sw = 0, lv;
    logic [5:0][CODE_W-1:0] sel = SEL_DEFAULT, v;
    logic select_rejected, run_forward, run_reverse, powerup_run_blocked, status_indicator_flash,
        local_mode_indicator, source_select_b, jog_select, freq_up, freq_down, bias_up,
        bias_down, forward_inch_request, reverse_inch_request, ramp_time_select, ramp_hold,
        output_shutoff, fast_stop, fault_reset, external_overheat_alarm, comm_mode,
        pid_input_switch, motor_2_select, timer_input, param_lockout, analog_ref_hold,
        dc_brake_request, drive_enable;
    logic [3:0] preset_index, pid_control;
    logic [2:0] offset_freq;
    logic [15:0] external_fault;
    logic [54:0] q [$];
    int fail_count = 0, compares = 0, seed = 58, cyc = 0;
    wire logic [54:0] obs = {fl, rej, source_select_b, local_mode_indicator, powerup_run_blocked,
        run_reverse, run_forward, drive_enable, bias_down, bias_up, freq_down, freq_up,
        dc_brake_request, analog_ref_hold, param_lockout, offset_freq, timer_input,
        motor_2_select, pid_input_switch, pid_control, comm_mode, external_overheat_alarm,
        fault_reset, external_fault, fast_stop, output_shutoff, ramp_hold, ramp_time_select,
        reverse_inch_request, forward_inch_request, jog_select, preset_index};

    mfid_contacts PM (.clk(clk), .close_req(sw), .level(lv));
    mfid_decoder #(.RUN_CLOSE_CYCLES(8), .FLASH_DIV_W(3)) DUT (.*,
        .input_terminal_1(lv[0]), .input_terminal_2(lv[1]), .input_terminal_3(lv[2]),
        .input_terminal_4(lv[3]), .input_terminal_5(lv[4]), .input_terminal_6(lv[5]),
        .terminal_1_function_select(sel[0]), .terminal_2_function_select(sel[1]),
        .terminal_3_function_select(sel[2]), .terminal_4_function_select(sel[3]),
        .terminal_5_function_select(sel[4]), .terminal_6_function_select(sel[5]));

    initial forever #20 clk = ~clk;

    // bit of the observed vector that a code should raise, -1 for none
    function automatic int fbit(int c);
        if (c >= 5 && c <= 9) return c - 5;
        if (c == 12 || c == 13) return c + 33;
        if (c >= 14 && c <= 16) return c - 9;
        if (c == 18 || c == 19) return c - 10;
        if (c == 21) return 10;
        if (c >= 23 && c <= 40) return c - 12;
        if (c >= 45 && c <= 55) return c - 16;
        if (c == 60 || c == 61) return c - 20;
        if (c == 65) return 42;
        return -1;
    endfunction

    task automatic load(logic [5:0][CODE_W-1:0] n);
        @(posedge clk);
        sel <= n;
        select_load <= 1;
        @(posedge clk);
        select_load <= 0;
    endtask

    // five edges cover the contact model, the synchroniser and the output register
    task automatic expect_obs(logic [54:0] e);
        repeat (5) @(posedge clk);
        q.push_back(e);
        chk <= 1;
        @(posedge clk);
        chk <= 0;
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(negedge clk) begin
        if (chk) begin
            compares++;
            if (obs !== q[0]) begin
                fail_count++;
                $display("[ERR] obs expected %h seen %h", q[0], obs);
            end
            void'(q.pop_front());
        end
    end

    // one-cycle pulses and the slow flash are held here so the delayed compare still sees them
    always @(posedge clk) begin
        rej <= select_load ? 1'b0 : rej | select_rejected;
        fl  <= reset ? 1'b0 : fl | status_indicator_flash;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 0;
        sw <= 6'h3c;
        expect_obs(DE | 55'h1 << 11 | 55'h1 << 27 | 55'h1 << 4 | 55'h1 << 9);
        $display("defaults done");
        // codes 74 and 75 must be refused, so the terminal keeps a retained code
        for (int c = 5; c < 76; c++) begin
            if (c inside {10, 11})
                continue;
            v = {6{7'h49}};
            v[$unsigned($random(seed)) % 6] = 7'(c);
            load(v);
            sw <= 6'h3f;
            expect_obs((fbit(c) < 0 ? DE : DE | 55'h1 << fbit(c))
                | (c > 73 ? REJ : 55'h0));
            sw <= 0;
        end
        $display("code sweep done");
        load({7'h49, 7'h49, 7'h49, 7'h49, 7'h0b, 7'h0a});
        for (int c = 0; c < 4; c++) begin
            sw <= 6'(c);
            expect_obs(DE | (c == 1 ? 55'h1 << 43 : c == 2 ? 55'h1 << 44 : 55'h0));
        end
        $display("up down done");
        load({7'h49, 7'h49, 7'h49, 7'h02, 7'h49, 7'h05});
        sw <= 6'h03;
        repeat (4) @(posedge clk);
        sw <= 6'h02;
        expect_obs(DE);
        sw <= 6'h03;
        repeat (12) @(posedge clk);
        expect_obs(DE | RF);
        sw <= 6'h06;
        expect_obs(DE | RR);
        sw <= 6'h04;
        @(posedge clk);
        sw <= 6'h06;
        expect_obs(DE);
        $display("three wire done");
        load({7'h49, 7'h04, 7'h03, 7'h49, 7'h49, 7'h49});
        sw <= 6'h08;
        expect_obs(DE | LOC);
        motor_running <= 1;
        sw <= 0;
        expect_obs(DE | LOC);
        motor_running <= 0;
        expect_obs(DE);
        keypad_source_toggle_key <= 1;
        @(posedge clk);
        keypad_source_toggle_key <= 0;
        expect_obs(DE);
        sw <= 6'h10;
        expect_obs(DE | SB);
        motor_running <= 1;
        sw <= 0;
        expect_obs(DE | SB);
        motor_running <= 0;
        $display("source select done");
        reset <= 1;
        sw <= 6'h01;
        powerup_run_accept <= 0;
        repeat (5) @(posedge clk);
        reset <= 0;
        repeat (6) @(posedge clk);
        expect_obs(DE | BLK | FLS);
        sw <= 0;
        expect_obs(DE | FLS);
        reset <= 1;
        sw <= 6'h01;
        powerup_run_accept <= 1;
        repeat (5) @(posedge clk);
        reset <= 0;
        expect_obs(DE | RF);
        sw <= 6'h02;
        expect_obs(DE | RR);
        keypad_source_toggle_key <= 1;
        @(posedge clk);
        keypad_source_toggle_key <= 0;
        expect_obs(DE | LOC);
        $display("power up done");
        summarize();
    end
endmodule // mfid_decoder_test
